// *** design/hmt_mode_ctrl.sv ***
// operating mode, standby, soft reset and fire control of the haptic driver
// assumes the serial bus front end presents one-cycle register requests on mclk
// and the playback, diagnostic and calibration engines report completion pulses

// Summary of operation
// - writing one to bit 7 aborts playback and restores every register default
// - bit 7 reads one until the reset action ends, then clears itself
// - bit 6 is standby, reset value 1; zero makes the device ready
// - mode bits 2-0 reset to 0; mode 0 fires by software fire bit
// - edge mode: a trigger rising edge while fire is clear sets fire and starts playback
// - edge mode: rising edge while fire is set and engine not done cancels the waveform
// - level mode: rise sets fire, fall cancels, engine completion also clears it
// - level mode: transition to the state already held changes nothing
// - mode 3 drives continuously from pin; select bit picks pwm or analog
// - mode 5 drives continuously from the realtime level value
// - mode 6: host fire write starts diagnostic; device clears fire when done
// - finished diagnostic records pass or fail in the check outcome flag
// - mode 7 fire runs auto calibration; fire clears when it finishes
// - check outcome 0 means pass, 1 means fail; clears when read
// - realtime value signed by default; format bit selects unsigned
module hmt_mode_ctrl (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire hmt_pkg::hmt_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic trigger_input_pin,
    input wire logic engine_done,
    input wire logic engine_fail,
    output hmt_pkg::hmt_engine_ctl_t engine_ctl
);
    import hmt_pkg::*;

    // ------------------------------------------------------------
    // trigger pin
    // ------------------------------------------------------------
    logic trig_rise;
    logic trig_fall;

    hmt_pin_sync u_trig_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_async(trigger_input_pin),
        .level(),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hmt_rst_state_t rst_state;
    hmt_rst_state_t next_rst_state;
    logic [7:0] rst_cnt;
    logic [7:0] next_rst_cnt;
    logic standby;
    logic next_standby;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic [7:0] rt_level;
    logic [7:0] next_rt_level;
    logic rt_unsigned;
    logic next_rt_unsigned;
    logic analog_sel;
    logic next_analog_sel;
    logic fire;
    logic next_fire;
    logic check_outcome;
    logic next_check_outcome;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    hmt_engine_ctl_t ctl;
    hmt_engine_ctl_t next_ctl;

    logic wr_mode;
    logic wr_fire;
    logic fire_mode;

    always_comb begin
        wr_mode = reg_req.wr && (reg_req.addr == ADDR_MODE);
        wr_fire = reg_req.wr && (reg_req.addr == ADDR_FIRE);
        fire_mode = (mode == MODE_INTERNAL) || (mode == MODE_DIAG) || (mode == MODE_CAL);

        next_rst_state = rst_state;
        next_rst_cnt = rst_cnt;
        next_standby = standby;
        next_mode = mode;
        next_rt_level = rt_level;
        next_rt_unsigned = rt_unsigned;
        next_analog_sel = analog_sel;
        next_fire = fire;
        next_check_outcome = check_outcome;
        next_rvalid = reg_req.rd;
        next_rdata = 8'h00;
        next_ctl = ctl;
        next_ctl.start = 1'b0;
        next_ctl.cancel = 1'b0;

        // ------------------------------------------------------------
        // soft reset sequence
        // ------------------------------------------------------------
        case (rst_state)
            RS_RUN: begin
                if (wr_mode && reg_req.wdata[BIT_SOFT_RESET]) begin
                    next_rst_state = RS_CLEAR;
                    next_rst_cnt = 8'(SOFT_RESET_CYCLES);
                end
            end
            RS_CLEAR: begin
                if (rst_cnt == 8'h01) begin
                    next_rst_state = RS_RUN;
                end
                next_rst_cnt = rst_cnt - 8'h01;
            end
            default: begin
                next_rst_state = RS_RUN;
            end
        endcase

        // ------------------------------------------------------------
        // register writes and fire control
        // ------------------------------------------------------------
        if (rst_state == RS_RUN && !(wr_mode && reg_req.wdata[BIT_SOFT_RESET])) begin
            if (wr_mode) begin
                next_standby = reg_req.wdata[BIT_STANDBY];
                next_mode = reg_req.wdata[MODE_MSB:0];
            end
            if (reg_req.wr && reg_req.addr == ADDR_RT_LEVEL) begin
                next_rt_level = reg_req.wdata;
            end
            if (reg_req.wr && reg_req.addr == ADDR_FORMAT) begin
                next_rt_unsigned = reg_req.wdata[BIT_RT_FORMAT];
                next_analog_sel = reg_req.wdata[BIT_ANALOG_SEL];
            end

            // engine completion clears fire in every mode
            if (fire && engine_done) begin
                next_fire = 1'b0;
            end

            // reserved mode 4 never fires
            if (!standby) begin
                if (wr_fire && fire_mode) begin
                    if (reg_req.wdata[BIT_FIRE] && !fire) begin
                        next_fire = 1'b1;
                        next_ctl.start = 1'b1;
                    end else if (!reg_req.wdata[BIT_FIRE] && fire) begin
                        next_fire = 1'b0;
                        next_ctl.cancel = 1'b1;
                    end
                end
                if (mode == MODE_EDGE && trig_rise) begin
                    if (fire && !engine_done) begin
                        next_fire = 1'b0;
                        next_ctl.cancel = 1'b1;
                    end else begin
                        next_fire = 1'b1;
                        next_ctl.start = 1'b1;
                    end
                end
                // fire already in the target state: nothing happens
                if (mode == MODE_LEVEL) begin
                    if (trig_rise && !fire) begin
                        next_fire = 1'b1;
                        next_ctl.start = 1'b1;
                    end else if (trig_fall && fire) begin
                        next_fire = 1'b0;
                        next_ctl.cancel = 1'b1;
                    end
                end
            end

            // outcome latches on diagnostic or calibration end; set beats read clear
            if (reg_req.rd && reg_req.addr == ADDR_STATUS) begin
                next_check_outcome = 1'b0;
            end
            if (fire && engine_done && (mode == MODE_DIAG || mode == MODE_CAL)) begin
                next_check_outcome = engine_fail;
            end
        end else begin
            // held at defaults for the whole reset action
            next_standby = RST_STANDBY;
            next_mode = RST_MODE;
            next_rt_level = RST_RT_LEVEL;
            next_rt_unsigned = RST_RT_FORMAT;
            next_analog_sel = RST_ANALOG_SEL;
            next_check_outcome = 1'b0;
            next_fire = 1'b0;
            next_ctl.cancel = fire;
        end

        // ------------------------------------------------------------
        // read data
        // ------------------------------------------------------------
        case (reg_req.addr)
            ADDR_STATUS: next_rdata[BIT_CHECK_OUTCOME] = check_outcome;
            ADDR_MODE: begin
                next_rdata[BIT_SOFT_RESET] = (rst_state == RS_CLEAR);
                next_rdata[BIT_STANDBY] = standby;
                next_rdata[MODE_MSB:0] = mode;
            end
            ADDR_RT_LEVEL: next_rdata = rt_level;
            ADDR_FIRE: next_rdata[BIT_FIRE] = fire;
            ADDR_FORMAT: begin
                next_rdata[BIT_RT_FORMAT] = rt_unsigned;
                next_rdata[BIT_ANALOG_SEL] = analog_sel;
            end
            default: next_rdata = 8'h00;
        endcase
        if (!reg_req.rd) begin
            next_rdata = rdata;
        end

        // ------------------------------------------------------------
        // engine drive controls
        // ------------------------------------------------------------
        next_ctl.mode = next_mode;
        next_ctl.standby = next_standby;
        // standby or mode 0 ends continuous drive
        next_ctl.active_drive = !next_standby &&
            (next_mode == MODE_PWM_ANALOG || next_mode == MODE_REALTIME);
        next_ctl.analog_sel = next_analog_sel;
        next_ctl.rt_level = next_rt_level;
        next_ctl.rt_unsigned = next_rt_unsigned;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rst_state <= RS_RUN;
            rst_cnt <= 8'h00;
            standby <= RST_STANDBY;
            mode <= RST_MODE;
            rt_level <= RST_RT_LEVEL;
            rt_unsigned <= RST_RT_FORMAT;
            analog_sel <= RST_ANALOG_SEL;
            fire <= 1'b0;
            check_outcome <= 1'b0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            ctl <= '{start: 1'b0, cancel: 1'b0, mode: RST_MODE, active_drive: 1'b0,
                     analog_sel: RST_ANALOG_SEL, rt_level: RST_RT_LEVEL,
                     rt_unsigned: RST_RT_FORMAT, standby: RST_STANDBY};
        end else begin
            rst_state <= next_rst_state;
            rst_cnt <= next_rst_cnt;
            standby <= next_standby;
            mode <= next_mode;
            rt_level <= next_rt_level;
            rt_unsigned <= next_rt_unsigned;
            analog_sel <= next_analog_sel;
            fire <= next_fire;
            check_outcome <= next_check_outcome;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            ctl <= next_ctl;
        end
    end

    always_comb begin
        reg_rdata = rdata;
        reg_rvalid = rvalid;
        engine_ctl = ctl;
    end
endmodule

// *** pkg/hmt_pkg.sv ***
// constants, types and register map of the haptic mode and trigger control
// assumes one 40 MHz clock shared with the serial register front end
package hmt_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_RT_LEVEL = 8'h02;
    localparam logic [7:0] ADDR_FIRE = 8'h0c;
    localparam logic [7:0] ADDR_FORMAT = 8'h1d;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_STANDBY = 6;
    localparam int MODE_MSB = 2;
    localparam int BIT_CHECK_OUTCOME = 3;
    localparam int BIT_FIRE = 0;
    localparam int BIT_RT_FORMAT = 3;
    localparam int BIT_ANALOG_SEL = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_STANDBY = 1'b1;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [7:0] RST_RT_LEVEL = 8'h00;
    localparam logic RST_RT_FORMAT = 1'b0;
    localparam logic RST_ANALOG_SEL = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SOFT_RESET_NS = 200;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'h0,
        MODE_EDGE = 3'h1,
        MODE_LEVEL = 3'h2,
        MODE_PWM_ANALOG = 3'h3,
        MODE_RESERVED = 3'h4,
        MODE_REALTIME = 3'h5,
        MODE_DIAG = 3'h6,
        MODE_CAL = 3'h7
    } hmt_mode_t;

    typedef enum logic [1:0] {
        RS_RUN = 2'b01,
        RS_CLEAR = 2'b10
    } hmt_rst_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hmt_reg_req_t;

    typedef struct packed {
        logic start;
        logic cancel;
        logic [2:0] mode;
        logic active_drive;
        logic analog_sel;
        logic [7:0] rt_level;
        logic rt_unsigned;
        logic standby;
    } hmt_engine_ctl_t;
endpackage

// *** design/hmt_pin_sync.sv ***
// two-flop synchroniser with edge detection for the trigger input pin
// assumes the pin is asynchronous to mclk
module hmt_pin_sync (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin_async,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stage;
    logic next_rise;
    logic next_fall;

    // only the second stage looks at meta
    always_comb begin
        next_rise = stage & ~level;
        next_fall = ~stage & level;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            stage <= 1'b0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            meta <= pin_async;
            stage <= meta;
            level <= stage;
            rise <= next_rise;
            fall <= next_fall;
        end
    end
endmodule

// *** bench/hmt_engine_model.sv ***
// behavioural playback, diagnostic and calibration engine facing the mode control
// assumes start and cancel are one-cycle pulses on mclk
module hmt_engine_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire hmt_pkg::hmt_engine_ctl_t ctl,
    input wire logic fail_cfg,
    output logic done,
    output logic fail
);
    timeunit 1ns;
    timeprecision 1ps;
    import hmt_pkg::*;
    localparam int JOB_CYCLES = 40;
    int cnt = 0;
    initial done = 1'b0;
    always @(posedge mclk) begin
        if (sys_rst || ctl.cancel) begin
            cnt <= 0;
            done <= 1'b0;
        end else if (ctl.start) begin
            cnt <= JOB_CYCLES;
            done <= 1'b0;
        end else if (cnt == 1) begin
            cnt <= 0;
            done <= 1'b1;
        end else begin
            cnt <= (cnt != 0) ? cnt - 1 : 0;
            done <= 1'b0;
        end
    end
    // outcome is only meaningful beside done; it toggles otherwise so nothing leans on it
    assign fail = done ? fail_cfg : cnt[0];
endmodule

// *** bench/hmt_mode_ctrl_assertions.sv ***
// port checker of the mode and trigger control
// assumes it is bound to hmt_mode_ctrl and sees only its ports
module hmt_mode_ctrl_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire hmt_pkg::hmt_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic trigger_input_pin,
    input wire logic engine_done,
    input wire logic engine_fail,
    input wire hmt_pkg::hmt_engine_ctl_t engine_ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    import hmt_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // soft reset window as seen from the ports; register writes inside it are ignored
    int soft_cnt;
    logic soft_busy;
    assign soft_busy = (soft_cnt != 0);
    always @(posedge mclk) begin
        if (sys_rst) begin
            soft_cnt <= 0;
        end else if (soft_cnt != 0) begin
            soft_cnt <= soft_cnt - 1;
        end else if (reg_req.wr && reg_req.addr == ADDR_MODE && reg_req.wdata[BIT_SOFT_RESET]) begin
            soft_cnt <= SOFT_RESET_CYCLES;
        end
    end
    property p_rst;
        $fell(sys_rst) |-> engine_ctl.standby && engine_ctl.mode == MODE_INTERNAL && !engine_ctl.start;
    endproperty
    a_rst: assert property (p_rst) else $error("reset defaults wrong");
    property p_soft;
        reg_req.wr && reg_req.addr == ADDR_MODE && reg_req.wdata[BIT_SOFT_RESET] |->
            ##[1:2] engine_ctl.standby && engine_ctl.mode == 3'h0;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset kept state");
    property p_busy;
        reg_req.rd && reg_req.addr == ADDR_MODE |=> reg_rdata[BIT_SOFT_RESET] == $past(soft_busy);
    endproperty
    a_busy: assert property (p_busy) else $error("soft reset bit wrong");
    property p_rsvd;
        reg_req.rd && reg_req.addr == ADDR_MODE |=> reg_rvalid && reg_rdata[5:3] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode bits not zero");
    property p_rt;
        reg_req.wr && reg_req.addr == ADDR_RT_LEVEL && !soft_busy |=> engine_ctl.rt_level == $past(reg_req.wdata);
    endproperty
    a_rt: assert property (p_rt) else $error("realtime level not taken");
    property p_fmt;
        reg_req.wr && reg_req.addr == ADDR_FORMAT && !soft_busy |=> engine_ctl.rt_unsigned == $past(reg_req.wdata[3]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format bit not taken");
    property p_drive;
        ((engine_ctl.mode == 3'h3 || engine_ctl.mode == 3'h5) && !engine_ctl.standby)[*3] |-> engine_ctl.active_drive;
    endproperty
    a_drive: assert property (p_drive) else $error("continuous drive missing");
    property p_stby;
        engine_ctl.standby[*3] |-> !engine_ctl.active_drive && !engine_ctl.start;
    endproperty
    a_stby: assert property (p_stby) else $error("activity in standby");
    property p_pulse;
        (engine_ctl.start |=> !engine_ctl.start) and (engine_ctl.cancel |=> !engine_ctl.cancel);
    endproperty
    a_pulse: assert property (p_pulse) else $error("start or cancel too long");
endmodule
bind hmt_mode_ctrl hmt_mode_ctrl_assertions i_chk (.mclk, .sys_rst, .reg_req, .reg_rdata, .reg_rvalid,
    .trigger_input_pin, .engine_done, .engine_fail, .engine_ctl);

// *** bench/hmt_mode_ctrl_bench.sv ***
// self-checking bench of the mode and trigger control
// assumes the engine model answers each start after a fixed job length
module hmt_mode_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import hmt_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    hmt_reg_req_t req = '0;
    logic pin = 1'b0;
    logic fail_cfg = 1'b0;
    logic [7:0] rdata;
    logic rvalid;
    logic done;
    logic fail;
    hmt_engine_ctl_t ctl;
    int num_errors = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_cancel = 0;
    always #12.5 mclk = ~mclk;
    hmt_mode_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .trigger_input_pin(pin), .engine_done(done), .engine_fail(fail), .engine_ctl(ctl));
    hmt_engine_model i_eng (.mclk(mclk), .sys_rst(sys_rst), .ctl(ctl), .fail_cfg(fail_cfg), .done(done), .fail(fail));
    always @(posedge mclk) begin
        if (ctl.start === 1'b1) n_start++;
        if (ctl.cancel === 1'b1) n_cancel++;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        check("rvalid", 8'h01, {7'h0, rvalid});
        check(name, exp, rdata);
    endtask
    // pulses stay far wider than the three cycles the synchroniser needs
    task automatic pin_to(input logic v);
        @(posedge mclk);
        pin <= v;
        repeat (8) @(posedge mclk);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge mclk);
        @(posedge mclk);
    endtask
    task automatic counts(input int s, input int c, input string name);
        check("starts", 8'(s), 8'(n_start));
        check("cancels", 8'(c), 8'(n_cancel));
        n_start = 0;
        n_cancel = 0;
        $display("test %s done", name);
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(ADDR_MODE, 8'h40, "mode default");
        rd(ADDR_RT_LEVEL, 8'h00, "rt default");
        rd(ADDR_FORMAT, 8'h00, "format default");
        rd(8'h55, 8'h00, "unmapped");
        wr(ADDR_FIRE, 8'h01);
        counts(0, 0, "defaults");
        wr(ADDR_MODE, 8'h3d);
        rd(ADDR_MODE, 8'h05, "mode reserved");
        wr(ADDR_RT_LEVEL, 8'h9a);
        rd(ADDR_RT_LEVEL, 8'h9a, "rt level");
        check("rt drive", 8'h9a, ctl.rt_level);
        check("rt active", 8'h01, {7'h0, ctl.active_drive});
        wr(ADDR_FORMAT, 8'h0a);
        wr(ADDR_MODE, 8'h03);
        rd(ADDR_MODE, 8'h03, "mode pwm");
        check("format", 8'h03, {6'h0, ctl.rt_unsigned, ctl.analog_sel});
        check("pwm active", 8'h01, {7'h0, ctl.active_drive});
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_MODE, 8'h00, "mode idle");
        check("idle mode 0", 8'h00, {7'h0, ctl.active_drive});
        wr(ADDR_MODE, 8'h45);
        rd(ADDR_MODE, 8'h45, "mode standby");
        check("idle", 8'h00, {7'h0, ctl.active_drive});
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_FIRE, 8'h01);
        rd(ADDR_FIRE, 8'h00, "reserved fire");
        counts(0, 0, "drive modes");
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_FIRE, 8'h01);
        rd(ADDR_FIRE, 8'h01, "fire set");
        wait_done();
        rd(ADDR_FIRE, 8'h00, "fire done");
        counts(1, 0, "internal");
        wr(ADDR_MODE, 8'h01);
        pin_to(1'b1);
        pin_to(1'b0);
        rd(ADDR_FIRE, 8'h01, "edge fire");
        pin_to(1'b1);
        pin_to(1'b0);
        counts(1, 1, "edge cancel");
        pin_to(1'b1);
        pin_to(1'b0);
        wait_done();
        rd(ADDR_FIRE, 8'h00, "edge done");
        counts(1, 0, "edge");
        wr(ADDR_MODE, 8'h02);
        pin_to(1'b1);
        rd(ADDR_FIRE, 8'h01, "level fire");
        pin_to(1'b0);
        counts(1, 1, "level");
        pin_to(1'b1);
        wait_done();
        rd(ADDR_FIRE, 8'h00, "level done");
        pin_to(1'b0);
        counts(1, 0, "level hold");
        @(posedge mclk);
        fail_cfg <= 1'b1;
        wr(ADDR_MODE, 8'h06);
        wr(ADDR_FIRE, 8'h01);
        wait_done();
        rd(ADDR_FIRE, 8'h00, "diag fire");
        rd(ADDR_STATUS, 8'h08, "diag fail");
        rd(ADDR_STATUS, 8'h00, "outcome read clear");
        // a second failed diagnostic leaves the flag set, so the passing calibration must clear it
        wr(ADDR_FIRE, 8'h01);
        wait_done();
        @(posedge mclk);
        fail_cfg <= 1'b0;
        // no calibration inputs sit in this block, so firing follows the mode write
        wr(ADDR_MODE, 8'h07);
        wr(ADDR_FIRE, 8'h01);
        wait_done();
        rd(ADDR_FIRE, 8'h00, "cal fire");
        rd(ADDR_STATUS, 8'h00, "cal pass");
        counts(3, 0, "diag and cal");
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_RT_LEVEL, 8'h33);
        wr(ADDR_FIRE, 8'h01);
        wr(ADDR_MODE, 8'h80);
        rd(ADDR_MODE, 8'hc0, "reset busy");
        wr(ADDR_RT_LEVEL, 8'h77);
        repeat (SOFT_RESET_CYCLES) @(posedge mclk);
        rd(ADDR_MODE, 8'h40, "reset over");
        rd(ADDR_RT_LEVEL, 8'h00, "rt restored");
        rd(ADDR_FORMAT, 8'h00, "format restored");
        rd(ADDR_FIRE, 8'h00, "fire restored");
        counts(1, 1, "soft reset");
        summarize();
    end
endmodule
